// ### cmp_config_regs.sv
// Purpose: Two configuration registers and digital output path of a comparator
// Assumes: Bus strobes and timer trigger are synchronous to clk
// Notes: Filter samples every clock, or on sample_in in sampling mode
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - Codes five to seven need that many agreeing samples
// R2 - Count one samples; zero bypasses filter; in sampling mode the code holds the filtered output at zero instead
// R3 - Config zero bits three, two read zero
// R4 - Two-bit hysteresis level drives analog comparator
// R5 - Bit seven selects sampling mode
// R6 - Bit six selects windowing mode
// R7 - Software never sets sampling and windowing together
// R8 - Bit five enables triggered compare mode
// R9 - Software enables comparator and ladder for trigger
// R10 - Standby until timer trigger enables each compare; code stays active after the first trigger until bit five or bit zero clears
// R11 - Bit four chooses low or high speed
// R12 - Bit three selects result polarity
// R13 - Adjusted result reaches pin and status bit
// R14 - Polarity clear leaves output uninverted
// R15 - Polarity set inverts output
// R16 - Bit zero enables comparator, else off
// R17 - Registers reset zero, read back on bus
module cmp_config_regs
  import cmp_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic analog_comparator,
  input wire logic window_in,
  input wire logic sample_in,
  input wire logic timer_trigger,
  output logic [1:0] hysteresis_level_select,
  output logic high_speed_compare,
  output logic comparator_power_on,
  output logic ladder_power_on,
  output logic filtered_compare_out,
  output logic raw_compare_out,
  output logic compare_pin_out,
  output logic compare_pin_oe
);
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] rdata;
    logic standby_done;
    logic raw;
    logic fout;
    logic pin;
    logic pin_oe;
    logic pwr;
  } regs_s;
  regs_s s_r;
  regs_s s_nxt;
  logic flipped;
  logic filt_out;
  logic [2:0] filter_agree_count;
  logic sampling_clocked_mode;
  logic window_mode;
  logic triggered_compare_mode;
  logic output_polarity_flip;
  logic output_pin_drive;
  logic comp_enable;
  logic compare_active;
  logic sample_tick;
  logic filt_bypass;
  logic fout_next;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] c0,
                                          input logic [7:0] c1);
    logic [7:0] v;
    v = 8'h00;
    if (a == CFG_ZERO_ADDR)
      v = c0 & CFG_ZERO_WMASK; // R3
    else if (a == CFG_ONE_ADDR)
      v = c1;
    return v;
  endfunction

  assign filter_agree_count = s_r.cfg0[CNT_MSB:CNT_LSB];
  assign sampling_clocked_mode = s_r.cfg1[SAMP_BIT]; // R5
  assign window_mode = s_r.cfg1[WIN_BIT]; // R6
  assign triggered_compare_mode = s_r.cfg1[TRIG_BIT]; // R8
  assign output_polarity_flip = s_r.cfg1[FLIP_BIT];
  assign output_pin_drive = s_r.cfg1[PIN_BIT];
  assign comp_enable = s_r.cfg1[EN_BIT]; // R16
  // Trigger mode holds the compare in standby until the timer fires
  assign compare_active = comp_enable && (!triggered_compare_mode || s_r.standby_done); // R10
  // Inversion ahead of window and filter
  assign flipped = output_polarity_flip ? ~analog_comparator : analog_comparator; // R12 R14 R15
  assign sample_tick = sampling_clocked_mode ? sample_in : 1'b1;
  assign filt_bypass = (filter_agree_count == CNT_OFF); // R2

  cmp_agree_filter u_filter (
    .clk(clk),
    .nrst(nrst),
    .sample_tick(sample_tick),
    .din(s_r.raw),
    .agree_count(filter_agree_count),
    .dout(filt_out)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    if (wr && addr == CFG_ZERO_ADDR)
      s_nxt.cfg0 = wdata & CFG_ZERO_WMASK; // R3 R17
    if (wr && addr == CFG_ONE_ADDR)
      s_nxt.cfg1 = wdata; // R17
    if (rd)
      s_nxt.rdata = read_mux(addr, s_r.cfg0, s_r.cfg1); // R17
    if (!triggered_compare_mode || !comp_enable)
      s_nxt.standby_done = 1'b0;
    else if (timer_trigger)
      s_nxt.standby_done = 1'b1; // R10
    s_nxt.pwr = compare_active;
    if (!compare_active)
      s_nxt.raw = s_r.raw;
    else if (!window_mode || window_in)
      s_nxt.raw = flipped; // R6
    if (filt_bypass)
      fout_next = sampling_clocked_mode ? 1'b0 : s_nxt.raw; // R2
    else
      fout_next = filt_out; // R1
    s_nxt.fout = fout_next;
    s_nxt.pin = s_r.cfg1[SEL_BIT] ? s_r.raw : s_r.fout; // R13
    s_nxt.pin_oe = output_pin_drive;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.cfg0 <= CFG_ZERO_RST;
      s_r.cfg1 <= CFG_ONE_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;
  assign hysteresis_level_select = s_r.cfg0[HYST_MSB:HYST_LSB]; // R4
  assign high_speed_compare = s_r.cfg1[SPEED_BIT]; // R11
  assign comparator_power_on = s_r.pwr; // R16
  assign ladder_power_on = s_r.pwr; // R8
  assign filtered_compare_out = s_r.fout;
  assign raw_compare_out = s_r.raw;
  assign compare_pin_out = s_r.pin; // R13
  assign compare_pin_oe = s_r.pin_oe;

  property p_reserved_zero;
    @(posedge clk) disable iff (!nrst)
      rd && addr == CFG_ZERO_ADDR |=> rdata[3:2] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // R3

  property p_readback;
    @(posedge clk) disable iff (!nrst)
      wr && addr == CFG_ONE_ADDR ##1 rd && addr == CFG_ONE_ADDR |=> rdata == $past(wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("config one readback wrong"); // R17

  property p_hyst;
    @(posedge clk) disable iff (!nrst)
      wr && addr == CFG_ZERO_ADDR |=> hysteresis_level_select == $past(wdata[1:0]);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not applied"); // R4

  property p_speed;
    @(posedge clk) disable iff (!nrst)
      wr && addr == CFG_ONE_ADDR |=> high_speed_compare == $past(wdata[4]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed choice wrong"); // R11

  property p_off;
    @(posedge clk) disable iff (!nrst)
      !comp_enable |=> !comparator_power_on;
  endproperty
  a_off: assert property (p_off) else $error("comparator powered while disabled"); // R16

  property p_standby;
    @(posedge clk) disable iff (!nrst)
      comp_enable && triggered_compare_mode && !s_r.standby_done && !timer_trigger
        |=> !comparator_power_on;
  endproperty
  a_standby: assert property (p_standby) else $error("left standby without trigger"); // R10

  property p_polarity;
    @(posedge clk) disable iff (!nrst)
      compare_active && !window_mode |=> raw_compare_out == $past(flipped);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity path wrong"); // R12

  property p_bypass;
    @(posedge clk) disable iff (!nrst)
      filt_bypass && !sampling_clocked_mode |=> filtered_compare_out == raw_compare_out;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output differs"); // R2

  property p_pin;
    @(posedge clk) disable iff (!nrst)
      !s_r.cfg1[SEL_BIT] |=> compare_pin_out == $past(filtered_compare_out);
  endproperty
  a_pin: assert property (p_pin) else $error("pin output wrong"); // R13

  property p_filter_hold;
    @(posedge clk) disable iff (!nrst)
      filter_agree_count == 3'h7 && !sampling_clocked_mode && !filt_bypass
        && $changed(raw_compare_out) |=> ##4 filtered_compare_out == $past(filtered_compare_out, 5);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter changed too early"); // R1

  property p_cfg0_write;
    @(posedge clk) disable iff (!nrst)
      wr && addr == CFG_ZERO_ADDR |=> s_r.cfg0 == ($past(wdata) & CFG_ZERO_WMASK);
  endproperty
  a_cfg0_write: assert property (p_cfg0_write) else $error("config zero write wrong"); // R3

  property p_cfg1_write;
    @(posedge clk) disable iff (!nrst)
      wr && addr == CFG_ONE_ADDR |=> s_r.cfg1 == $past(wdata);
  endproperty
  a_cfg1_write: assert property (p_cfg1_write) else $error("config one write wrong"); // R17

  property p_cfg0_hold;
    @(posedge clk) disable iff (!nrst)
      !(wr && addr == CFG_ZERO_ADDR) |=> $stable(s_r.cfg0);
  endproperty
  a_cfg0_hold: assert property (p_cfg0_hold) else $error("config zero changed unasked"); // R17

  property p_cfg1_hold;
    @(posedge clk) disable iff (!nrst)
      !(wr && addr == CFG_ONE_ADDR) |=> $stable(s_r.cfg1);
  endproperty
  a_cfg1_hold: assert property (p_cfg1_hold) else $error("config one changed unasked"); // R17

  property p_rdata_idle;
    @(posedge clk) disable iff (!nrst)
      !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot"); // R17

  property p_rdata_one;
    @(posedge clk) disable iff (!nrst)
      rd && addr == CFG_ONE_ADDR |=> rdata == $past(s_r.cfg1);
  endproperty
  a_rdata_one: assert property (p_rdata_one) else $error("config one read wrong"); // R17

  property p_rdata_zero;
    @(posedge clk) disable iff (!nrst)
      rd && addr == CFG_ZERO_ADDR |=> rdata == ($past(s_r.cfg0) & CFG_ZERO_WMASK);
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("config zero read wrong"); // R3

  property p_unmapped;
    @(posedge clk) disable iff (!nrst)
      rd && addr != CFG_ZERO_ADDR && addr != CFG_ONE_ADDR |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // R17

  property p_cfg0_reserved;
    @(posedge clk) disable iff (!nrst)
      1'b1 |-> s_r.cfg0[3:2] == 2'b00;
  endproperty
  a_cfg0_reserved: assert property (p_cfg0_reserved) else $error("reserved bits stored"); // R3

  property p_window_hold;
    @(posedge clk) disable iff (!nrst)
      compare_active && window_mode && !window_in |=> $stable(raw_compare_out);
  endproperty
  a_window_hold: assert property (p_window_hold) else $error("closed window sampled"); // R6

  property p_window_pass;
    @(posedge clk) disable iff (!nrst)
      compare_active && window_mode && window_in |=> raw_compare_out == $past(flipped);
  endproperty
  a_window_pass: assert property (p_window_pass) else $error("open window missed"); // R6

  property p_disabled_hold;
    @(posedge clk) disable iff (!nrst)
      !compare_active |=> $stable(raw_compare_out);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("idle compare moved"); // R16

  property p_samp_zero;
    @(posedge clk) disable iff (!nrst)
      filt_bypass && sampling_clocked_mode |=> !filtered_compare_out;
  endproperty
  a_samp_zero: assert property (p_samp_zero) else $error("bypass in sampling not zero"); // R2

  // Without a sample pulse the filter must not move in sampling mode
  property p_samp_no_tick;
    @(posedge clk) disable iff (!nrst)
      sampling_clocked_mode && !sample_in && !filt_bypass && !wr
        |=> ##1 filtered_compare_out == $past(filtered_compare_out);
  endproperty
  a_samp_no_tick: assert property (p_samp_no_tick) else $error("filter moved untimed"); // R5

  property p_pin_raw;
    @(posedge clk) disable iff (!nrst)
      s_r.cfg1[SEL_BIT] |=> compare_pin_out == $past(raw_compare_out);
  endproperty
  a_pin_raw: assert property (p_pin_raw) else $error("pin raw path wrong"); // R13

  property p_pin_oe;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> compare_pin_oe == $past(output_pin_drive);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong"); // R13

  property p_trig_wake;
    @(posedge clk) disable iff (!nrst)
      comp_enable && triggered_compare_mode && timer_trigger && !wr |=> ##1 comparator_power_on;
  endproperty
  a_trig_wake: assert property (p_trig_wake) else $error("trigger did not wake"); // R10

  property p_trig_off;
    @(posedge clk) disable iff (!nrst)
      comp_enable && !triggered_compare_mode |=> comparator_power_on;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("enabled compare not powered"); // R8

  property p_ladder;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> ladder_power_on == $past(compare_active);
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder power wrong"); // R8

  property p_hyst_hold;
    @(posedge clk) disable iff (!nrst)
      !(wr && addr == CFG_ZERO_ADDR) |=> $stable(hysteresis_level_select);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis changed unasked"); // R4

  property p_flip_off;
    @(posedge clk) disable iff (!nrst)
      compare_active && !window_mode && !output_polarity_flip
        |=> raw_compare_out == $past(analog_comparator);
  endproperty
  a_flip_off: assert property (p_flip_off) else $error("result inverted unasked"); // R14

  property p_flip_on;
    @(posedge clk) disable iff (!nrst)
      compare_active && !window_mode && output_polarity_flip
        |=> raw_compare_out == !$past(analog_comparator);
  endproperty
  a_flip_on: assert property (p_flip_on) else $error("result not inverted"); // R15

  property p_filtered_path;
    @(posedge clk) disable iff (!nrst)
      !filt_bypass |=> filtered_compare_out == $past(filt_out);
  endproperty
  a_filtered_path: assert property (p_filtered_path) else $error("filter output lost"); // R1
endmodule
`default_nettype wire

// ### cmp_cfg_pkg.sv
// Purpose: Constants for the comparator configuration register bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Offsets are register indices
package cmp_cfg_pkg;
  localparam logic [7:0] CFG_ZERO_ADDR = 8'h00;
  localparam logic [7:0] CFG_ONE_ADDR = 8'h01;
  localparam logic [7:0] CFG_ZERO_RST = 8'h00;
  localparam logic [7:0] CFG_ONE_RST = 8'h00;
  localparam logic [7:0] CFG_ZERO_WMASK = 8'h73;
  localparam int CNT_LSB = 4;
  localparam int CNT_MSB = 6;
  localparam int HYST_LSB = 0;
  localparam int HYST_MSB = 1;
  localparam int SAMP_BIT = 7;
  localparam int WIN_BIT = 6;
  localparam int TRIG_BIT = 5;
  localparam int SPEED_BIT = 4;
  localparam int FLIP_BIT = 3;
  localparam int SEL_BIT = 2;
  localparam int PIN_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic [2:0] CNT_OFF = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
endpackage

// ### cmp_agree_filter.sv
// Purpose: Consecutive-sample agreement filter
// Assumes: sample_tick marks one filter sample
// Notes: Output changes after count equal samples differ from it
`timescale 1ns/100ps
`default_nettype none
module cmp_agree_filter
  import cmp_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_tick,
  input wire logic din,
  input wire logic [2:0] agree_count,
  output logic dout
);
  typedef struct packed {
    logic out;
    logic cand;
    logic [2:0] run;
  } filt_s;
  filt_s s_r;
  filt_s s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (sample_tick && agree_count != CNT_OFF)
    begin
      if (din == s_r.out)
      begin
        s_nxt.run = 3'h0;
      end
      else
      begin
        // Run restarts if the candidate level changes mid-run
        s_nxt.run = (din == s_r.cand) ? s_r.run + 3'h1 : 3'h1;
        s_nxt.cand = din;
        if (((din == s_r.cand) ? s_r.run + 3'h1 : 3'h1) >= agree_count) // R1
        begin
          s_nxt.out = din;
          s_nxt.run = 3'h0;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign dout = s_r.out;
endmodule
`default_nettype wire

// ### cmp_timer_model.sv
// Purpose: Periodic timer trigger source facing the comparator
// Assumes: run gates the trigger train
// Notes: One-cycle pulse every PERIOD clocks, none while run is low
`timescale 1ns/100ps
`default_nettype none
module cmp_timer_model #(
  parameter int PERIOD = 12
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic trig
);
  int cnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 0;
      trig <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      trig <= run && (cnt == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

// ### cmp_config_regs_bench.sv
// Purpose: Self-checking bench for the comparator configuration registers
// Assumes: Reads are queued and checked by a separate monitor
// Notes: Trigger check allows one spare edge for the trigger pickup
`timescale 1ns/100ps
`default_nettype none
module cmp_config_regs_bench;
  import cmp_cfg_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, ana = 0, win = 0, smp = 0, run = 0, rd_d = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, w;
  logic [1:0] hyst;
  logic hs, pwr, lad, filt, raw, pin, oe, trig;
  int n_mismatch = 0, checks_done = 0;
  logic [7:0] q[$];
  always #2.5 clk = ~clk;
  cmp_config_regs u_cmp_config_regs (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .analog_comparator(ana), .window_in(win),
    .sample_in(smp), .timer_trigger(trig), .hysteresis_level_select(hyst),
    .high_speed_compare(hs), .comparator_power_on(pwr), .ladder_power_on(lad),
    .filtered_compare_out(filt), .raw_compare_out(raw), .compare_pin_out(pin),
    .compare_pin_oe(oe));
  cmp_timer_model u_cmp_timer_model (.clk(clk), .nrst(nrst), .run(run), .trig(trig));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Sample just past the edge so registered outputs have settled
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d && q.size() > 0)
      chk("rdata", q.pop_front(), rdata);
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h47E9));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rreg(CFG_ZERO_ADDR, CFG_ZERO_RST);
    rreg(CFG_ONE_ADDR, CFG_ONE_RST);
    for (int i = 0; i < 4; i++)
    begin
      w = $urandom();
      wreg(CFG_ZERO_ADDR, w);
      rreg(CFG_ZERO_ADDR, w & CFG_ZERO_WMASK);
      wait_n(2);
      chk("hyst", {6'h00, w[1:0]}, {6'h00, hyst});
      w = $urandom();
      // Software never sets sampling and windowing together
      w[6] = w[6] & ~w[7];
      wreg(CFG_ONE_ADDR, w);
      rreg(CFG_ONE_ADDR, w);
      wait_n(2);
      chk("speed", w[4], hs);
    end
    rreg(8'h05, 8'h00);
    wreg(CFG_ZERO_ADDR, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wreg(CFG_ONE_ADDR, {4'h0, i[1], i[0], 2'b11});
      @(posedge clk) ana <= i[0];
      wait_n(4);
      chk("raw", i[0] ^ i[1], raw);
      chk("filt", i[0] ^ i[1], filt);
      chk("pin", i[0] ^ i[1], pin);
      chk("oe", 8'h01, oe);
    end
    for (int n = 5; n < 8; n++)
    begin
      wreg(CFG_ZERO_ADDR, 8'(n << 4));
      wreg(CFG_ONE_ADDR, 8'h01);
      @(posedge clk) ana <= 1'b0;
      wait_n(12);
      // A run one sample short must not get through
      @(posedge clk) ana <= 1'b1;
      repeat (n - 1) @(posedge clk);
      ana <= 1'b0;
      wait_n(n + 3);
      chk("short", 8'h00, filt);
      @(posedge clk) ana <= 1'b1;
      wait_n(n);
      chk("early", 8'h00, filt);
      wait_n(3);
      chk("late", 8'h01, filt);
    end
    wreg(CFG_ZERO_ADDR, 8'h10);
    wreg(CFG_ONE_ADDR, 8'h81);
    @(posedge clk) ana <= 1'b0;
    wait_n(6);
    chk("hold", 8'h01, filt);
    @(posedge clk) smp <= 1'b1;
    @(posedge clk) smp <= 1'b0;
    wait_n(4);
    chk("samp", 8'h00, filt);
    wreg(CFG_ZERO_ADDR, 8'h00);
    wreg(CFG_ONE_ADDR, 8'h41);
    @(posedge clk) ana <= 1'b1;
    wait_n(4);
    chk("win_lo", 8'h00, raw);
    @(posedge clk) win <= 1'b1;
    wait_n(4);
    chk("win_hi", 8'h01, raw);
    wreg(CFG_ONE_ADDR, 8'h21);
    wait_n(20);
    chk("standby", 8'h00, {lad, pwr});
    @(posedge clk) run <= 1'b1;
    for (int k = 0; k < 40 && trig !== 1'b1; k++)
      wait_n(1);
    wait_n(3);
    chk("armed", 8'h03, {lad, pwr});
    wreg(CFG_ONE_ADDR, 8'h20);
    wait_n(3);
    chk("off", 8'h00, {lad, pwr});
    wreg(CFG_ONE_ADDR, 8'h01);
    wait_n(3);
    chk("on", 8'h03, {lad, pwr});
    summarize();
  end
endmodule
`default_nettype wire
